// *** bcu_bridge_control.sv ***
// Bridge control upper fields: APB register slave and response control.
// Assumes abort events are one-cycle pulses on clk.
// How it works
// - Fast back-to-back only while bit 7 set
// - Bit 6 set drives secondary reset out
// - Bit 6 resets 0; holds reset while 1
// - Mode clear: aborted reads return all ones
// - Mode clear: aborted write data dropped silently
// - Mode set: PCI read master abort returns UR
// - Mode set: UR completion becomes target abort
// - Full decode matters only with VGA enable
// - Full decode clear: ignore bits 15:10
// - Full decode set: match bits 15:10
// - VGA ranges 3B0-3BB, 3C0-3DF, upper zero
module bcu_bridge_control
(
    input wire logic clk, // Clock
    input wire logic nrst, // Sync reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [11:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic b2b_request, // Datapath wants back-to-back
    output logic b2b_allow, // Back-to-back permitted
    output logic secondary_reset_out, // Secondary reset, high = reset
    input wire logic io_valid, // I/O request address valid
    input wire logic [31:0] io_addr, // I/O request address
    output logic vga_forward, // Forward as VGA I/O
    input wire logic pci_rd_abort, // PCI read master abort
    input wire logic pci_wr_abort, // PCI posted write master abort
    input wire logic pcie_ur_cpl, // UR completion from link
    input wire logic [31:0] rd_data_in, // Read data from PCI
    output logic [31:0] rd_data_out, // Read data to requester
    output logic ur_cpl, // Return UR completion
    output logic target_abort, // Target abort on PCI
    output logic wr_err, // Posted write error report
    output logic irq // Interrupt, level
);
    typedef struct packed {
        logic [15:0] ctrl;
        logic [2:0] status;
        logic [2:0] mask;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic b2b_allow;
        logic secondary_bus_reset_request_out;
        logic vga_forward;
        logic [31:0] rd_data;
        logic ur_cpl;
        logic target_abort;
        logic wr_err;
        logic irq;
    } bcu_state_t;

    bcu_state_t st_reg;
    bcu_state_t st_next;
    logic vga_hit;
    logic [31:0] map_data;
    logic map_ur;
    logic map_ta;
    logic map_werr;
    logic [2:0] events;
    logic access;
    logic [2:0] clear;

    bcu_vga_decode u_vga
    (
        .io_addr(io_addr),
        .full_decode(st_reg.ctrl[bcu_pkg::vga_full_io_decode_bit]),
        .hit(vga_hit)
    );

    bcu_abort_map u_map
    (
        .mode(st_reg.ctrl[bcu_pkg::mam_bit]),
        .pci_rd_abort(pci_rd_abort),
        .pci_wr_abort(pci_wr_abort),
        .pcie_ur_cpl(pcie_ur_cpl),
        .rd_data_in(rd_data_in),
        .rd_data_out(map_data),
        .ur_cpl(map_ur),
        .target_abort(map_ta),
        .wr_err(map_werr)
    );

    always_comb
    begin
        st_next = st_reg;
        access = psel && penable && !st_reg.pready;
        events = 3'h0;
        events[bcu_pkg::ev_rd_abort] = pci_rd_abort;
        events[bcu_pkg::ev_wr_abort] = pci_wr_abort;
        events[bcu_pkg::ev_ur_cpl] = pcie_ur_cpl;
        clear = 3'h0;
        st_next.pready = access;
        st_next.pslverr = 1'b0;
        st_next.prdata = 32'h00000000;
        if (access)
        begin
            case (paddr)
                bcu_pkg::ctrl_off:
                begin
                    if (pwrite)
                    begin
                        st_next.ctrl = pwdata[15:0] & bcu_pkg::ctrl_wmask;
                    end
                    st_next.prdata = {16'h0000, st_reg.ctrl};
                end
                bcu_pkg::status_off:
                begin
                    if (pwrite)
                    begin
                        clear = pwdata[2:0];
                    end
                    st_next.prdata = {29'h00000000, st_reg.status};
                end
                bcu_pkg::mask_off:
                begin
                    if (pwrite)
                    begin
                        st_next.mask = pwdata[2:0];
                    end
                    st_next.prdata = {29'h00000000, st_reg.mask};
                end
                default:
                begin
                    st_next.pslverr = 1'b1;
                end
            endcase
            if (!pwrite && !st_next.pslverr)
            begin
                st_next.prdata = st_next.prdata;
            end
        end
        // Set wins over write-one-to-clear
        st_next.status = (st_reg.status & ~clear) | events;
        st_next.b2b_allow = b2b_request && st_reg.ctrl[bcu_pkg::fbb_bit];
        st_next.secondary_bus_reset_request_out = st_reg.ctrl[bcu_pkg::secondary_bus_reset_request_bit];
        st_next.vga_forward = io_valid && vga_hit && st_reg.ctrl[bcu_pkg::vga_en_bit];
        st_next.rd_data = map_data;
        st_next.ur_cpl = map_ur;
        st_next.target_abort = map_ta;
        st_next.wr_err = map_werr;
        st_next.irq = |(st_next.status & st_next.mask);
        if (!nrst)
        begin
            st_next = '0;
            st_next.ctrl = bcu_pkg::ctrl_reset;
            st_next.status = bcu_pkg::ev_reset;
            st_next.mask = bcu_pkg::ev_reset;
        end
    end

    always_ff @(posedge clk)
    begin
        st_reg <= st_next;
    end

    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign b2b_allow = st_reg.b2b_allow;
    assign secondary_reset_out = st_reg.secondary_bus_reset_request_out;
    assign vga_forward = st_reg.vga_forward;
    assign rd_data_out = st_reg.rd_data;
    assign ur_cpl = st_reg.ur_cpl;
    assign target_abort = st_reg.target_abort;
    assign wr_err = st_reg.wr_err;
    assign irq = st_reg.irq;

    fbb_gated_a: assert property (@(posedge clk) disable iff (!nrst)
        b2b_allow |-> $past(st_reg.ctrl[bcu_pkg::fbb_bit]))
        else $error("back-to-back allowed while disabled");
    secondary_bus_reset_request_follow_a: assert property (@(posedge clk) disable iff (!nrst)
        $rose(st_reg.ctrl[bcu_pkg::secondary_bus_reset_request_bit]) |=> secondary_reset_out)
        else $error("secondary reset not asserted");
    secondary_bus_reset_request_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        st_reg.ctrl[bcu_pkg::secondary_bus_reset_request_bit] [*2] |-> secondary_reset_out)
        else $error("secondary reset dropped while requested");
    rd_ones_a: assert property (@(posedge clk) disable iff (!nrst)
        (pci_rd_abort && !st_reg.ctrl[bcu_pkg::mam_bit]) |=> (rd_data_out == bcu_pkg::all_ones))
        else $error("aborted read not all ones");
    wr_silent_a: assert property (@(posedge clk) disable iff (!nrst)
        !st_reg.ctrl[bcu_pkg::mam_bit] |=> !wr_err)
        else $error("write abort reported in silent mode");
    ur_return_a: assert property (@(posedge clk) disable iff (!nrst)
        (pci_rd_abort && st_reg.ctrl[bcu_pkg::mam_bit]) |=> ur_cpl)
        else $error("master abort not returned as UR");
    ta_return_a: assert property (@(posedge clk) disable iff (!nrst)
        (pcie_ur_cpl && st_reg.ctrl[bcu_pkg::mam_bit]) |=> target_abort)
        else $error("UR not signalled as target abort");
    wr_report_a: assert property (@(posedge clk) disable iff (!nrst)
        (pci_wr_abort && st_reg.ctrl[bcu_pkg::mam_bit]) |=> wr_err)
        else $error("posted write abort not reported");
    vga_gate_a: assert property (@(posedge clk) disable iff (!nrst)
        vga_forward |-> $past(st_reg.ctrl[bcu_pkg::vga_en_bit]))
        else $error("VGA forward without VGA enable");
    vga_alias_a: assert property (@(posedge clk) disable iff (!nrst)
        (io_valid && st_reg.ctrl[bcu_pkg::vga_en_bit] && st_reg.ctrl[bcu_pkg::vga_full_io_decode_bit]
        && (io_addr[15:10] != 6'h00)) |=> !vga_forward)
        else $error("alias matched under full decode");
    vga_range_a: assert property (@(posedge clk) disable iff (!nrst)
        (io_valid && st_reg.ctrl[bcu_pkg::vga_en_bit] && !st_reg.ctrl[bcu_pkg::vga_full_io_decode_bit]
        && (io_addr[31:16] == 16'h0000) && (io_addr[9:0] == 10'h3C5)) |=> vga_forward)
        else $error("VGA alias not matched");
endmodule : bcu_bridge_control

// *** bcu_pkg.sv ***
// Package for the bridge control upper fields block.
// Assumes a 32-bit APB register bus with word-aligned registers.
package bcu_pkg;
    localparam logic [11:0] ctrl_off = 12'h000;
    localparam logic [11:0] status_off = 12'h004;
    localparam logic [11:0] mask_off = 12'h008;
    localparam int ctrl_width = 16;
    localparam int fbb_bit = 7;
    localparam int secondary_bus_reset_request_bit = 6;
    localparam int mam_bit = 5;
    localparam int vga_full_io_decode_bit = 4;
    localparam int vga_en_bit = 3;
    localparam logic [15:0] ctrl_reset = 16'h0000;
    localparam logic [15:0] ctrl_wmask = 16'h00F8;
    localparam int ev_rd_abort = 0;
    localparam int ev_wr_abort = 1;
    localparam int ev_ur_cpl = 2;
    localparam int ev_width = 3;
    localparam logic [2:0] ev_reset = 3'h0;
    localparam logic [31:0] all_ones = 32'hFFFFFFFF;
    localparam logic [15:0] io_hi_zero = 16'h0000;
    localparam logic [9:0] vga_lo1_min = 10'h3B0;
    localparam logic [9:0] vga_lo1_max = 10'h3BB;
    localparam logic [9:0] vga_lo2_min = 10'h3C0;
    localparam logic [9:0] vga_lo2_max = 10'h3DF;
    localparam logic [5:0] alias_zero = 6'h00;
    typedef enum logic [1:0] {
        bcu_idle = 2'b00,
        bcu_access = 2'b01
    } bcu_apb_state_t;
endpackage : bcu_pkg

// *** bcu_vga_decode.sv ***
// VGA I/O address match with optional 16-bit full decode.
// Assumes the caller qualifies with VGA enable.
module bcu_vga_decode
(
    input wire logic [31:0] io_addr, // I/O address
    input wire logic full_decode, // Include bits 15:10
    output logic hit // Address is VGA I/O
);
    logic lo_hit;
    always_comb
    begin
        lo_hit = ((io_addr[9:0] >= bcu_pkg::vga_lo1_min) && (io_addr[9:0] <= bcu_pkg::vga_lo1_max))
            || ((io_addr[9:0] >= bcu_pkg::vga_lo2_min) && (io_addr[9:0] <= bcu_pkg::vga_lo2_max));
        hit = (io_addr[31:16] == bcu_pkg::io_hi_zero) && lo_hit
            && (!full_decode || (io_addr[15:10] == bcu_pkg::alias_zero));
    end
endmodule : bcu_vga_decode

// *** bcu_abort_map.sv ***
// Maps abort outcomes to responses per the report mode.
// Purely combinational; events come from the forwarding datapath.
module bcu_abort_map
(
    input wire logic mode, // Master abort report mode
    input wire logic pci_rd_abort, // PCI read master abort
    input wire logic pci_wr_abort, // PCI posted write master abort
    input wire logic pcie_ur_cpl, // UR completion from link
    input wire logic [31:0] rd_data_in, // Read data from PCI
    output logic [31:0] rd_data_out, // Read data to requester
    output logic ur_cpl, // Return UR completion
    output logic target_abort, // Signal target abort on PCI
    output logic wr_err // Posted write error report
);
    always_comb
    begin
        rd_data_out = (pci_rd_abort && !mode) ? bcu_pkg::all_ones : rd_data_in;
        ur_cpl = mode && pci_rd_abort;
        target_abort = mode && pcie_ur_cpl;
        wr_err = mode && pci_wr_abort;
    end
endmodule : bcu_abort_map

// *** bcu_pci_agent.sv ***
// Far-side model: abort events and read data from the secondary bus.
// Assumes the bench calls pulse; events are driven just after rising edges.
module bcu_pci_agent
(
    input wire logic clk, // Clock
    output logic pci_rd_abort, // Read master abort
    output logic pci_wr_abort, // Posted write master abort
    output logic pcie_ur_cpl, // UR completion
    output logic [31:0] rd_data_in // Read data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        {pcie_ur_cpl, pci_wr_abort, pci_rd_abort} = 3'h0;
        rd_data_in = 32'h5A5A0F0F;
    end
    // One-cycle event; data inverted afterwards so stale data shows up
    task automatic pulse(input logic [2:0] e, input logic [31:0] d);
        @(posedge clk);
        {pcie_ur_cpl, pci_wr_abort, pci_rd_abort} <= e;
        rd_data_in <= d;
        @(posedge clk);
        {pcie_ur_cpl, pci_wr_abort, pci_rd_abort} <= 3'h0;
        rd_data_in <= ~d;
    endtask : pulse
endmodule : bcu_pci_agent

// *** bcu_bridge_control_tb.sv ***
// Testbench for the bridge control block: APB tests and event checks.
// Assumes the design answers APB with one wait state.
module bcu_bridge_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic b2b_request = 1'b1;
    logic io_valid = 1'b0;
    logic [31:0] io_addr = 32'h0;
    logic [31:0] prdata, rd_data_in, rd_data_out;
    logic pready, pslverr, b2b_allow, secondary_reset_out, vga_forward;
    logic pci_rd_abort, pci_wr_abort, pcie_ur_cpl, ur_cpl, target_abort, wr_err, irq;
    int failures = 0;
    int n_tests = 0;
    always #2.5 clk = ~clk;
    bcu_bridge_control u_bcu_bridge_control (.clk, .nrst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .b2b_request, .b2b_allow,
        .secondary_reset_out, .io_valid, .io_addr, .vga_forward, .pci_rd_abort,
        .pci_wr_abort, .pcie_ur_cpl, .rd_data_in, .rd_data_out, .ur_cpl,
        .target_abort, .wr_err, .irq);
    bcu_pci_agent u_bcu_pci_agent (.clk, .pci_rd_abort, .pci_wr_abort, .pcie_ur_cpl,
        .rd_data_in);
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("FAIL at %0t: got %08h expected %08h", $time, got, exp);
        end
    endtask : chk
    task automatic step;
        @(posedge clk);
        #1;
    endtask : step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
            failures++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk({31'h0, e}, {31'h0, xe});
        if (!xe)
            chk(r, x);
    endtask : rd
    task automatic io(input logic [31:0] a, input logic x);
        @(posedge clk);
        io_valid <= 1'b1;
        io_addr <= a;
        step();
        chk({31'h0, vga_forward}, {31'h0, x});
    endtask : io
    task automatic ev(input logic [2:0] e, input logic [31:0] d, input logic [31:0] xd,
                      input logic [2:0] xo);
        u_bcu_pci_agent.pulse(e, d);
        #1;
        chk(rd_data_out, xd);
        chk({29'h0, wr_err, target_abort, ur_cpl}, {29'h0, xo});
    endtask : ev
    task automatic ctl(input logic [31:0] v, input logic [1:0] x);
        wr(bcu_pkg::ctrl_off, v);
        step();
        chk({30'h0, b2b_allow, secondary_reset_out}, {30'h0, x});
    endtask : ctl
    initial
    begin
        #100000;
        failures++;
        end_of_test();
    end
    initial
    begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        rd(bcu_pkg::ctrl_off, 32'h0, 1'b0);
        rd(bcu_pkg::status_off, 32'h0, 1'b0);
        rd(bcu_pkg::mask_off, 32'h0, 1'b0);
        rd(12'h00C, 32'h0, 1'b1);
        chk({30'h0, b2b_allow, secondary_reset_out}, 32'h0);
        $display("test reset done");
        ctl(32'h0000FFFF, 2'h3);
        rd(bcu_pkg::ctrl_off, 32'h000000F8, 1'b0);
        io(32'h0000FBB0, 1'b0);
        io(32'h000003B0, 1'b1);
        io(32'h000003DF, 1'b1);
        io(32'h000003E0, 1'b0);
        io(32'h000103B0, 1'b0);
        ctl(32'h00000008, 2'h0);
        io(32'h0000FBB0, 1'b1);
        io(32'h0000FFC5, 1'b1);
        io(32'h000003BB, 1'b1);
        io(32'h000003BC, 1'b0);
        wr(bcu_pkg::ctrl_off, 32'h00000010);
        io(32'h000003B0, 1'b0);
        $display("test ctrl and decode done");
        ev(3'h1, 32'h12345678, 32'hFFFFFFFF, 3'h0);
        ev(3'h2, 32'h0F0F0F0F, 32'h0F0F0F0F, 3'h0);
        ev(3'h4, 32'h89ABCDEF, 32'h89ABCDEF, 3'h0);
        wr(bcu_pkg::ctrl_off, 32'h00000020);
        ev(3'h1, 32'h12345678, 32'h12345678, 3'h1);
        ev(3'h4, 32'h00C0FFEE, 32'h00C0FFEE, 3'h2);
        ev(3'h2, 32'h13579BDF, 32'h13579BDF, 3'h4);
        $display("test abort mode done");
        rd(bcu_pkg::status_off, 32'h00000007, 1'b0);
        chk({31'h0, irq}, 32'h0);
        wr(bcu_pkg::mask_off, 32'h00000004);
        step();
        chk({31'h0, irq}, 32'h1);
        wr(bcu_pkg::status_off, 32'h00000004);
        rd(bcu_pkg::status_off, 32'h00000003, 1'b0);
        step();
        chk({31'h0, irq}, 32'h0);
        rd(bcu_pkg::mask_off, 32'h00000004, 1'b0);
        $display("test interrupt done");
        end_of_test();
    end
endmodule : bcu_bridge_control_tb
